// *** include/rf_frame_pkg.sv ***
package rf_frame_pkg;

    // ****************************************
    // register indices, byte address is 4x
    // ****************************************
    localparam logic [7:0]  IDX_TX_GUARD_CTRL   = 8'h31;
    localparam logic [7:0]  IDX_TX_GUARD_LOW    = 8'h32;
    localparam logic [7:0]  IDX_FRAME_FORMAT    = 8'h33;
    localparam logic [7:0]  IDX_RX_FRAME_START  = 8'h34;
    localparam logic [7:0]  IDX_RX_CONTROL      = 8'h35;
    localparam logic [7:0]  IDX_RX_BLANKING     = 8'h36;
    localparam logic [7:0]  IDX_RX_THRESHOLD    = 8'h37;
    localparam int          ADDR_W              = 12;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0]  RST_TX_GUARD_CTRL   = 8'hC0;
    localparam logic [7:0]  RST_ZERO            = 8'h00;

    // ****************************************
    // field positions
    // ****************************************
    localparam int          B_GUARD_START       = 7;
    localparam int          B_GUARD_UNIT        = 6;
    localparam int          B_GUARD_HI_MSB      = 5;
    localparam int          B_GUARD_HI_LSB      = 3;
    localparam int          B_TX_PARITY         = 7;
    localparam int          B_RX_PARITY         = 6;
    localparam int          B_END_SYM_MSB       = 3;
    localparam int          B_END_SYM_LSB       = 2;
    localparam int          B_BEGIN_SYM_MSB     = 1;
    localparam int          B_BEGIN_SYM_LSB     = 0;
    localparam int          B_SOF_EN            = 5;
    localparam int          B_SOF_SEEN          = 4;
    localparam int          B_SUB_EN            = 2;
    localparam int          B_SUB_SEEN          = 1;
    localparam int          B_SUB_NOW           = 0;
    localparam int          B_PARTIAL_WRITE     = 7;
    localparam int          B_CONTINUOUS        = 6;
    localparam int          B_FILTER_EN         = 3;
    localparam int          B_BAUD_MSB          = 2;
    localparam int          B_BLANK_UNIT        = 7;
    localparam int          B_BLANK_MSB         = 6;
    localparam int          B_AMP_MSB           = 7;
    localparam int          B_AMP_LSB           = 4;
    localparam int          B_PHASE_MSB         = 3;

    // ****************************************
    // encodings and counts
    // ****************************************
    localparam logic [2:0]  BAUD_26K            = 3'h2;
    localparam logic [2:0]  BAUD_52K            = 3'h3;
    localparam logic [1:0]  FILTER_BYTES        = 2'h3;

    // ****************************************
    // timing
    // ****************************************
    localparam int          CLK_KHZ             = 100000;
    localparam int          CARRIER_KHZ         = 13560;
    localparam int          CARRIER_PERIODS     = 16;
    localparam int          BAUD_26K_HZ         = 26000;
    localparam int          BAUD_52K_HZ         = 52000;
    localparam int          CARRIER_UNIT_CYC    =
        (CARRIER_PERIODS * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
    localparam int          HALF_BIT_26K_CYC    =
        (CLK_KHZ * 1000 + 2 * BAUD_26K_HZ - 1) / (2 * BAUD_26K_HZ);
    localparam int          HALF_BIT_52K_CYC    =
        (CLK_KHZ * 1000 + 2 * BAUD_52K_HZ - 1) / (2 * BAUD_52K_HZ);
    localparam int          PRE_W               = 12;

endpackage : rf_frame_pkg

// *** core/rf_frame_ctrl.sv ***
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module rf_frame_ctrl
    import rf_frame_pkg::*;
(
    input  wire logic                I_REF_CLK,
    input  wire logic                I_RESET,
    input  wire logic                i_PSEL,
    input  wire logic                i_PENABLE,
    input  wire logic                i_PWRITE,
    input  wire logic [ADDR_W-1:0]   i_PADDR,
    input  wire logic [31:0]         i_PWDATA,
    output logic      [31:0]         o_PRDATA,
    output logic                     o_PREADY,
    output logic                     o_PSLVERR,
    input  wire logic                i_TX_REQ,
    input  wire logic                i_TX_END,
    input  wire logic                i_TX_BYTE_VALID,
    input  wire logic [7:0]          i_TX_BYTE,
    input  wire logic                i_SOF_DETECT,
    input  wire logic                i_SUBCARRIER_NOW,
    input  wire logic                i_RX_BYTE_VALID,
    input  wire logic [7:0]          i_RX_BYTE,
    input  wire logic                i_RX_PARITY,
    input  wire logic                i_RX_PARTIAL,
    input  wire logic                i_RX_ERROR,
    input  wire logic                i_RX_END,
    input  wire logic                i_CRC_EN,
    input  wire logic [7:0]          i_ERROR_REG,
    output logic                     o_TX_GO,
    output logic                     o_TX_PARITY_VALID,
    output logic                     o_TX_PARITY_BIT,
    output logic      [1:0]          o_BEGIN_SYMBOL_SEL,
    output logic      [1:0]          o_END_SYMBOL_SEL,
    output logic                     o_RX_BLANK,
    output logic                     o_RX_PARITY_ERR,
    output logic                     o_FIFO_WE,
    output logic      [7:0]          o_FIFO_WDATA,
    output logic                     o_FIFO_CLR,
    output logic                     o_RX_IRQ,
    output logic                     o_RX_DONE,
    output logic                     o_FRAME_START_IRQ,
    output logic      [3:0]          o_MIN_AMPLITUDE_LEVEL,
    output logic      [3:0]          o_MIN_PHASE_LEVEL
);

    // ****************************************
    // register storage
    // ****************************************
    logic [7:0]  tx_guard_ctrl_reg;
    logic [7:0]  tx_guard_low_reg;
    logic [7:0]  frame_format_reg;
    logic [1:0]  frame_start_en_reg;
    logic        sof_seen_reg;
    logic        subcarrier_seen_reg;
    logic [7:0]  rx_control_reg;
    logic [7:0]  rx_blanking_reg;
    logic [7:0]  rx_threshold_reg;

    logic [7:0]  idx;
    logic        mapped;
    logic        wr_en;
    logic        setup;
    logic [7:0]  rd_next;
    logic [10:0] tx_guard_value;
    logic [PRE_W-1:0] half_bit_cyc;

    assign idx            = i_PADDR[9:2];
    assign setup          = i_PSEL && !i_PENABLE;
    assign wr_en          = i_PSEL && i_PENABLE && o_PREADY && i_PWRITE
                            && !o_PSLVERR;
    assign tx_guard_value = {tx_guard_ctrl_reg[B_GUARD_HI_MSB:B_GUARD_HI_LSB],
                             tx_guard_low_reg};

    // ****************************************
    // address decode and read mux
    // ****************************************
    always_comb
    begin
        mapped  = (i_PADDR[1:0] == 2'h0) && (i_PADDR[ADDR_W-1:10] == '0);
        rd_next = 8'h00;
        case (idx)
            IDX_TX_GUARD_CTRL:  rd_next = {tx_guard_ctrl_reg[7:3], 3'h0};
            IDX_TX_GUARD_LOW:   rd_next = tx_guard_low_reg;
            IDX_FRAME_FORMAT:   rd_next = {frame_format_reg[7:6], 2'h0,
                                           frame_format_reg[3:0]};
            IDX_RX_FRAME_START: rd_next = {2'h0, frame_start_en_reg[1],
                                           sof_seen_reg, 1'b0,
                                           frame_start_en_reg[0],
                                           subcarrier_seen_reg,
                                           i_SUBCARRIER_NOW};
            IDX_RX_CONTROL:     rd_next = {rx_control_reg[7:6], 2'h0,
                                           rx_control_reg[3:0]};
            IDX_RX_BLANKING:    rd_next = rx_blanking_reg;
            IDX_RX_THRESHOLD:   rd_next = rx_threshold_reg;
            default:            mapped  = 1'b0;
        endcase
    end

    // ****************************************
    // apb answer, ready in the access phase
    // ****************************************
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            o_PREADY  <= 1'b0;
            o_PSLVERR <= 1'b0;
            o_PRDATA  <= 32'h0000_0000;
        end
        else
        begin
            o_PREADY  <= setup;
            o_PSLVERR <= setup && !mapped;
            if (setup)
            begin
                o_PRDATA <= i_PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_next};
            end
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            tx_guard_ctrl_reg  <= RST_TX_GUARD_CTRL;
            tx_guard_low_reg   <= RST_ZERO;
            frame_format_reg   <= RST_ZERO;
            frame_start_en_reg <= 2'h0;
            rx_control_reg     <= RST_ZERO;
            rx_blanking_reg    <= RST_ZERO;
            rx_threshold_reg   <= RST_ZERO;
        end
        else if (wr_en)
        begin
            case (idx)
                IDX_TX_GUARD_CTRL:  tx_guard_ctrl_reg  <= i_PWDATA[7:0];
                IDX_TX_GUARD_LOW:   tx_guard_low_reg   <= i_PWDATA[7:0];
                IDX_FRAME_FORMAT:   frame_format_reg   <= i_PWDATA[7:0];
                IDX_RX_FRAME_START: frame_start_en_reg <=
                    {i_PWDATA[B_SOF_EN], i_PWDATA[B_SUB_EN]};
                IDX_RX_CONTROL:     rx_control_reg     <= i_PWDATA[7:0];
                IDX_RX_BLANKING:    rx_blanking_reg    <= i_PWDATA[7:0];
                IDX_RX_THRESHOLD:   rx_threshold_reg   <= i_PWDATA[7:0];
                default:            ;
            endcase
        end
    end

    // ****************************************
    // sticky detect flags, write one clears
    // ****************************************
    logic sticky_clr;
    logic blank_reg;
    assign sticky_clr = wr_en && (idx == IDX_RX_FRAME_START);

    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            sof_seen_reg        <= 1'b0;
            subcarrier_seen_reg <= 1'b0;
        end
        else
        begin
            if (i_SOF_DETECT && !blank_reg)
                sof_seen_reg <= 1'b1;
            else if (sticky_clr && i_PWDATA[B_SOF_SEEN])
                sof_seen_reg <= 1'b0;
            if (i_SUBCARRIER_NOW && !blank_reg)
                subcarrier_seen_reg <= 1'b1;
            else if (sticky_clr && i_PWDATA[B_SUB_SEEN])
                subcarrier_seen_reg <= 1'b0;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            o_FRAME_START_IRQ <= 1'b0;
        else
            o_FRAME_START_IRQ <= (frame_start_en_reg[1] && sof_seen_reg)
                || (frame_start_en_reg[0] && subcarrier_seen_reg);
    end

    // ****************************************
    // time units
    // ****************************************
    always_comb
    begin
        case (rx_control_reg[B_BAUD_MSB:0])
            BAUD_52K: half_bit_cyc = PRE_W'(HALF_BIT_52K_CYC);
            BAUD_26K: half_bit_cyc = PRE_W'(HALF_BIT_26K_CYC);
            default:  half_bit_cyc = PRE_W'(HALF_BIT_26K_CYC);
        endcase
    end

    // ****************************************
    // transmit guard
    // ****************************************
    logic [PRE_W-1:0] guard_pre_reg;
    logic [10:0]      guard_units_reg;
    logic             guard_run_reg;
    logic             tx_pending_reg;
    logic [PRE_W-1:0] guard_len;
    logic             guard_start;
    logic             guard_done;

    assign guard_len   = tx_guard_ctrl_reg[B_GUARD_UNIT] ? half_bit_cyc
                         : PRE_W'(CARRIER_UNIT_CYC);
    assign guard_start = tx_guard_ctrl_reg[B_GUARD_START] ? i_RX_END
                         : i_TX_END;
    assign guard_done  = !guard_run_reg || (guard_units_reg >= tx_guard_value);

    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            guard_pre_reg   <= '0;
            guard_units_reg <= '0;
            guard_run_reg   <= 1'b0;
        end
        else if (guard_start)
        begin
            guard_pre_reg   <= '0;
            guard_units_reg <= '0;
            guard_run_reg   <= 1'b1;
        end
        else if (guard_run_reg)
        begin
            if (guard_units_reg >= tx_guard_value)
                guard_run_reg <= 1'b0;
            else if (guard_pre_reg >= guard_len - PRE_W'(1))
            begin
                guard_pre_reg   <= '0;
                guard_units_reg <= guard_units_reg + 11'h001;
            end
            else
                guard_pre_reg <= guard_pre_reg + PRE_W'(1);
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            tx_pending_reg <= 1'b0;
            o_TX_GO        <= 1'b0;
        end
        else
        begin
            o_TX_GO <= 1'b0;
            if ((tx_pending_reg || i_TX_REQ) && guard_done && !guard_start)
            begin
                tx_pending_reg <= 1'b0;
                o_TX_GO        <= 1'b1;
            end
            else if (i_TX_REQ)
                tx_pending_reg <= 1'b1;
        end
    end

    // ****************************************
    // transmit framing
    // ****************************************
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            o_TX_PARITY_VALID  <= 1'b0;
            o_TX_PARITY_BIT    <= 1'b0;
            o_BEGIN_SYMBOL_SEL <= 2'h0;
            o_END_SYMBOL_SEL   <= 2'h0;
        end
        else
        begin
            o_TX_PARITY_VALID  <= i_TX_BYTE_VALID
                                  && frame_format_reg[B_TX_PARITY];
            o_TX_PARITY_BIT    <= ~(^i_TX_BYTE);
            o_BEGIN_SYMBOL_SEL <=
                frame_format_reg[B_BEGIN_SYM_MSB:B_BEGIN_SYM_LSB];
            o_END_SYMBOL_SEL   <=
                frame_format_reg[B_END_SYM_MSB:B_END_SYM_LSB];
        end
    end

    // ****************************************
    // receive blanking
    // ****************************************
    logic [PRE_W-1:0] blank_pre_reg;
    logic [6:0]       blank_units_reg;
    logic [PRE_W-1:0] blank_len;

    assign blank_len = rx_blanking_reg[B_BLANK_UNIT] ? half_bit_cyc
                       : PRE_W'(CARRIER_UNIT_CYC);

    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            blank_pre_reg   <= '0;
            blank_units_reg <= '0;
            blank_reg       <= 1'b0;
        end
        else if (i_TX_END)
        begin
            blank_pre_reg   <= '0;
            blank_units_reg <= '0;
            blank_reg       <= (rx_blanking_reg[B_BLANK_MSB:0] != 7'h00);
        end
        else if (blank_reg)
        begin
            if (blank_pre_reg >= blank_len - PRE_W'(1))
            begin
                blank_pre_reg   <= '0;
                blank_units_reg <= blank_units_reg + 7'h01;
                if (blank_units_reg + 7'h01 >= rx_blanking_reg[B_BLANK_MSB:0])
                    blank_reg <= 1'b0;
            end
            else
                blank_pre_reg <= blank_pre_reg + PRE_W'(1);
        end
    end

    assign o_RX_BLANK = blank_reg;

    // ****************************************
    // receive path to the FIFO
    // ****************************************
    logic       rx_byte_ok;
    logic       rx_end_ok;
    logic       keep_byte;
    logic       early;
    logic [1:0] byte_cnt_reg;
    logic       err_byte_reg;

    assign rx_byte_ok = i_RX_BYTE_VALID && !blank_reg;
    assign rx_end_ok  = i_RX_END && !blank_reg;
    assign keep_byte  = !i_RX_PARTIAL || !i_CRC_EN
                        || rx_control_reg[B_PARTIAL_WRITE];
    assign early      = rx_control_reg[B_FILTER_EN]
                        && (byte_cnt_reg < FILTER_BYTES);

    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            byte_cnt_reg <= 2'h0;
        else if (rx_end_ok || (early && i_RX_ERROR && !blank_reg))
            byte_cnt_reg <= 2'h0;
        else if (rx_byte_ok && byte_cnt_reg != FILTER_BYTES)
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
    end

    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            o_FIFO_WE       <= 1'b0;
            o_FIFO_WDATA    <= 8'h00;
            o_FIFO_CLR      <= 1'b0;
            o_RX_IRQ        <= 1'b0;
            o_RX_DONE       <= 1'b0;
            o_RX_PARITY_ERR <= 1'b0;
            err_byte_reg    <= 1'b0;
        end
        else
        begin
            o_FIFO_WE       <= 1'b0;
            o_FIFO_CLR      <= 1'b0;
            o_RX_IRQ        <= 1'b0;
            o_RX_DONE       <= 1'b0;
            err_byte_reg    <= 1'b0;
            o_RX_PARITY_ERR <= 1'b0;
            if (rx_byte_ok && frame_format_reg[B_RX_PARITY])
                o_RX_PARITY_ERR <= (i_RX_PARITY == (^i_RX_BYTE));
            if (early && !blank_reg
                && (i_RX_ERROR || (rx_end_ok && !rx_byte_ok)))
                o_FIFO_CLR <= 1'b1;
            else
            begin
                if (rx_byte_ok && keep_byte)
                begin
                    o_FIFO_WE    <= 1'b1;
                    o_FIFO_WDATA <= i_RX_BYTE;
                end
                if (err_byte_reg && !(rx_byte_ok && keep_byte))
                begin
                    o_FIFO_WE    <= 1'b1;
                    o_FIFO_WDATA <= i_ERROR_REG;
                end
                if (rx_end_ok)
                begin
                    o_RX_IRQ <= 1'b1;
                    if (rx_control_reg[B_CONTINUOUS])
                        err_byte_reg <= 1'b1;
                    else
                        o_RX_DONE <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // decoder thresholds
    // ****************************************
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            o_MIN_AMPLITUDE_LEVEL <= 4'h0;
            o_MIN_PHASE_LEVEL     <= 4'h0;
        end
        else
        begin
            o_MIN_AMPLITUDE_LEVEL <=
                rx_threshold_reg[B_AMP_MSB:B_AMP_LSB];
            o_MIN_PHASE_LEVEL     <= rx_threshold_reg[B_PHASE_MSB:0];
        end
    end

endmodule : rf_frame_ctrl

// *** test/rf_frame_properties.sv ***
`timescale 1ns/1ps
module rf_frame_properties (
    input wire logic       I_REF_CLK,
    input wire logic       I_RESET,
    input wire logic       i_PSEL,
    input wire logic       i_PENABLE,
    input wire logic       i_PWRITE,
    input wire logic       o_PREADY,
    input wire logic       i_TX_BYTE_VALID,
    input wire logic [7:0] i_TX_BYTE,
    input wire logic       o_TX_PARITY_VALID,
    input wire logic       o_TX_PARITY_BIT,
    input wire logic       i_RX_BYTE_VALID,
    input wire logic [7:0] i_RX_BYTE,
    input wire logic       i_RX_PARTIAL,
    input wire logic       i_RX_ERROR,
    input wire logic       o_RX_BLANK,
    input wire logic       o_FIFO_WE,
    input wire logic [7:0] o_FIFO_WDATA,
    input wire logic       o_TX_GO,
    input wire logic       o_FIFO_CLR,
    input wire logic       o_RX_IRQ,
    input wire logic [3:0] o_MIN_AMPLITUDE_LEVEL,
    input wire logic [3:0] o_MIN_PHASE_LEVEL
);
    // ****************
    // port checks
    // ****************
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RESET);
    wire wr_done = i_PSEL && i_PENABLE && i_PWRITE && o_PREADY;
    wire rx_ok = i_RX_BYTE_VALID && !o_RX_BLANK && !i_RX_PARTIAL;
    AST_PAR_CAUSE:
        assert property (o_TX_PARITY_VALID |-> $past(i_TX_BYTE_VALID))
        else $error("stray parity strobe");
    AST_PAR_BIT:
        assert property (o_TX_PARITY_VALID |->
            o_TX_PARITY_BIT == ~^$past(i_TX_BYTE))
        else $error("wrong tx parity bit");
    AST_FIFO_WE:
        assert property (rx_ok && !i_RX_ERROR |=> o_FIFO_WE)
        else $error("byte not written");
    AST_FIFO_DATA:
        assert property (o_FIFO_WE && $past(i_RX_BYTE_VALID) |->
            o_FIFO_WDATA == $past(i_RX_BYTE))
        else $error("wrong fifo byte");
    AST_GO_PULSE:
        assert property (o_TX_GO |=> !o_TX_GO)
        else $error("go too long");
    AST_CLR_QUIET:
        assert property (o_FIFO_CLR |-> !o_RX_IRQ [*3])
        else $error("irq with fifo clear");
    AST_AMP_HOLD:
        assert property (!$stable(o_MIN_AMPLITUDE_LEVEL) |-> $past(wr_done, 2))
        else $error("amplitude level moved");
    AST_PHASE_HOLD:
        assert property (!$stable(o_MIN_PHASE_LEVEL) |-> $past(wr_done, 2))
        else $error("phase level moved");
endmodule : rf_frame_properties

// *** test/rf_tag_model.sv ***
`timescale 1ns/1ps
module rf_tag_model (
    input  wire logic i_clk,
    output logic      o_sof,
    output logic      o_valid,
    output logic [7:0] o_byte,
    output logic      o_par,
    output logic      o_err,
    output logic      o_end
);
    // ****************
    // frame sender
    // ****************
    initial
    begin
        {o_sof, o_valid, o_par, o_err, o_end} = '0;
        o_byte = 8'hA5;
    end
    task automatic frame(input int n, input int bad);
        @(posedge i_clk) o_sof <= 1'b1;
        @(posedge i_clk) o_sof <= 1'b0;
        for (int k = 0; k < n; k++)
        begin
            @(posedge i_clk);
            o_valid <= 1'b1;
            o_byte <= 8'h30 + 8'(k);
            o_par <= ~^(8'h30 + 8'(k));
            o_err <= (k == bad);
            @(posedge i_clk);
            o_valid <= 1'b0;
            o_err <= 1'b0;
            o_byte <= ~o_byte;
        end
        @(posedge i_clk) o_end <= 1'b1;
        @(posedge i_clk) o_end <= 1'b0;
    endtask : frame
endmodule : rf_tag_model

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench
    import rf_frame_pkg::*;
;
    logic I_REF_CLK, I_RESET, i_PSEL, i_PENABLE, i_PWRITE, i_TX_REQ;
    logic i_TX_END, i_TX_BYTE_VALID, i_SOF_DETECT, i_SUBCARRIER_NOW;
    logic i_RX_BYTE_VALID, i_RX_PARITY, i_RX_PARTIAL, i_RX_ERROR;
    logic i_RX_END, i_CRC_EN, o_PREADY, o_PSLVERR, o_TX_GO, o_RX_BLANK;
    logic o_TX_PARITY_VALID, o_TX_PARITY_BIT, o_RX_PARITY_ERR, o_FIFO_WE;
    logic o_FIFO_CLR, o_RX_IRQ, o_RX_DONE, o_FRAME_START_IRQ, slv;
    logic [ADDR_W-1:0] i_PADDR;
    logic [31:0] i_PWDATA, o_PRDATA;
    logic [7:0] i_TX_BYTE, i_RX_BYTE, i_ERROR_REG, o_FIFO_WDATA, rdat, lastw;
    logic [1:0] o_BEGIN_SYMBOL_SEL, o_END_SYMBOL_SEL;
    logic [3:0] o_MIN_AMPLITUDE_LEVEL, o_MIN_PHASE_LEVEL;
    int fails, num_checks, nb, nwe, nirq, ndone, nclr, h;
    localparam int CU = CARRIER_UNIT_CYC;
    rf_frame_ctrl u_dut (.*);
    rf_tag_model u_tag (.i_clk(I_REF_CLK), .o_sof(i_SOF_DETECT),
        .o_valid(i_RX_BYTE_VALID), .o_byte(i_RX_BYTE), .o_par(i_RX_PARITY),
        .o_err(i_RX_ERROR), .o_end(i_RX_END));
    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic chkr(input int g, input int lo, input int hi);
        num_checks++;
        if (g < lo || g > hi)
        begin
            fails++;
            $display("ERROR t=%0t got %h exp %h..%h", $time, g, lo, hi);
        end
    endtask : chkr
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int t;
        @(posedge I_REF_CLK);
        i_PSEL <= 1'b1;
        i_PWRITE <= w;
        i_PADDR <= {2'b00, a, 2'b00};
        i_PWDATA <= {24'h0, d};
        @(posedge I_REF_CLK);
        i_PENABLE <= 1'b1;
        t = 0;
        @(posedge I_REF_CLK);
        while (o_PREADY !== 1'b1 && t < 50)
        begin
            @(posedge I_REF_CLK);
            t++;
        end
        fails += int'(t >= 50);
        rdat = o_PRDATA[7:0];
        slv = o_PSLVERR;
        i_PSEL <= 1'b0;
        i_PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rdat, e);
    endtask : rd
    task automatic xmit(input logic e, input int lo);
        int n;
        @(posedge I_REF_CLK);
        i_TX_END <= e;
        i_TX_REQ <= 1'b1;
        @(posedge I_REF_CLK);
        i_TX_END <= 1'b0;
        i_TX_REQ <= 1'b0;
        n = 1;
        nb = 0;
        while (o_TX_GO !== 1'b1 && n < 40000)
        begin
            @(posedge I_REF_CLK);
            n++;
            nb += int'(o_RX_BLANK === 1'b1);
        end
        chkr(n, lo, lo + 6);
    endtask : xmit
    task automatic rxf(input int n, input int bad);
        {nwe, nirq, ndone, nclr} = '0;
        u_tag.frame(n, bad);
        repeat (4) @(posedge I_REF_CLK);
    endtask : rxf
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    always @(posedge I_REF_CLK)
    begin
        nwe += int'(o_FIFO_WE === 1'b1);
        nirq += int'(o_RX_IRQ === 1'b1);
        ndone += int'(o_RX_DONE === 1'b1)
            + 16 * int'(o_RX_PARITY_ERR !== 1'b0);
        nclr += int'(o_FIFO_CLR === 1'b1);
        if (o_FIFO_WE === 1'b1)
            lastw = o_FIFO_WDATA;
    end
    // ****************
    // sequence
    // ****************
    initial
    begin
        I_REF_CLK = 1'b0;
        forever #5 I_REF_CLK = ~I_REF_CLK;
    end
    initial
    begin
        #1000000;
        fails++;
        close_out;
    end
    initial
    begin
        {i_PSEL, i_PENABLE, i_PWRITE, i_TX_REQ, i_TX_END} = '0;
        {i_TX_BYTE_VALID, i_SUBCARRIER_NOW, i_RX_PARTIAL} = '0;
        {i_PADDR, i_PWDATA, i_TX_BYTE} = '0;
        i_CRC_EN = 1'b1;
        i_ERROR_REG = 8'h5A;
        I_RESET = 1'b1;
        repeat (12) @(posedge I_REF_CLK);
        I_RESET <= 1'b0;
        for (int k = 8'h31; k < 8'h38; k++)
            rd(8'(k), k == 8'h31 ? RST_TX_GUARD_CTRL : RST_ZERO);
        rd(8'h10, 8'h00);
        chk({7'h0, slv}, 8'h01);
        wr(IDX_RX_THRESHOLD, 8'hA5);
        wr(IDX_TX_GUARD_CTRL, 8'hFF);
        rd(IDX_TX_GUARD_CTRL, 8'hF8);
        chk({o_MIN_AMPLITUDE_LEVEL, o_MIN_PHASE_LEVEL}, 8'hA5);
        for (int c = 0; c < 4; c++)
        begin
            h = 12 - 3 * c;
            wr(IDX_FRAME_FORMAT, 8'hF0 | 8'(h));
            rd(IDX_FRAME_FORMAT, 8'hC0 | 8'(h));
            chk({4'h0, o_END_SYMBOL_SEL, o_BEGIN_SYMBOL_SEL}, 8'(h));
        end
        for (int b = 0; b < 3; b++)
        begin
            @(posedge I_REF_CLK);
            i_TX_BYTE_VALID <= 1'b1;
            i_TX_BYTE <= 8'h81 + 8'(b);
            @(posedge I_REF_CLK);
            i_TX_BYTE_VALID <= 1'b0;
        end
        wr(IDX_RX_BLANKING, 8'h02);
        wr(IDX_TX_GUARD_CTRL, 8'h08);
        wr(IDX_TX_GUARD_LOW, 8'h01);
        xmit(1'b1, 257 * CU);
        chkr(nb, 2 * CU - 1, 2 * CU + 2);
        xmit(1'b0, 1);
        wr(IDX_TX_GUARD_CTRL, 8'h40);
        wr(IDX_RX_BLANKING, 8'h81);
        for (int c = 2; c < 4; c++)
        begin
            wr(IDX_RX_CONTROL, 8'(c));
            h = c == 2 ? HALF_BIT_26K_CYC : HALF_BIT_52K_CYC;
            xmit(1'b1, h);
            chkr(nb, h - 3, h + 2);
        end
        wr(IDX_RX_BLANKING, 8'h00);
        wr(IDX_TX_GUARD_CTRL, 8'h80);
        wr(IDX_TX_GUARD_LOW, 8'h02);
        wr(IDX_RX_FRAME_START, 8'h24);
        rxf(4, 9);
        chk(8'(nwe), 8'h04);
        chk(8'(nirq * 16 + ndone), 8'h11);
        xmit(1'b0, 2 * CU - 8);
        chk({7'h0, o_FRAME_START_IRQ}, 8'h01);
        rd(IDX_RX_FRAME_START, 8'h34);
        i_SUBCARRIER_NOW <= 1'b1;
        rd(IDX_RX_FRAME_START, 8'h37);
        i_SUBCARRIER_NOW <= 1'b0;
        rd(IDX_RX_FRAME_START, 8'h36);
        wr(IDX_RX_FRAME_START, 8'h32);
        rd(IDX_RX_FRAME_START, 8'h20);
        chk({7'h0, o_FRAME_START_IRQ}, 8'h00);
        wr(IDX_RX_FRAME_START, 8'h04);
        i_SUBCARRIER_NOW <= 1'b1;
        rd(IDX_RX_FRAME_START, 8'h07);
        chk({7'h0, o_FRAME_START_IRQ}, 8'h01);
        i_SUBCARRIER_NOW <= 1'b0;
        wr(IDX_RX_CONTROL, 8'h43);
        rxf(4, 9);
        chk(8'(nwe * 16 + ndone), 8'h50);
        chk(lastw, i_ERROR_REG);
        wr(IDX_RX_CONTROL, 8'h0B);
        rxf(4, 1);
        chk(8'(nirq * 16 + int'(nclr > 0)), 8'h01);
        rxf(2, 9);
        chk(8'(nirq * 16 + int'(nclr > 0)), 8'h01);
        close_out;
    end
endmodule : testbench
bind rf_frame_ctrl rf_frame_properties u_props (.*);
